// *** core/test_run_pkg.sv ***
// Package of constants and types for the test-run sequencer
package test_run_pkg;

    // ----------------------------------------------------------------
    // Modes and encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DUR_CONTINUOUS = 2'h0,
        DUR_SINGLE     = 2'h1,
        DUR_REPEAT     = 2'h2
    } dur_mode_type;

    typedef enum logic [2:0] {
        TRIG_OFF     = 3'h0,
        TRIG_END     = 3'h1,
        TRIG_ERROR   = 3'h2,
        TRIG_EVERY15 = 3'h3,
        TRIG_EVERY2H = 3'h4
    } trig_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_END  = 2'b11
    } run_state_type;

    // Duration setting as three binary fields
    typedef struct packed {
        logic [6:0] hours;
        logic [5:0] minutes;
        logic [5:0] seconds;
    } hms_type;

    // Trigger pulses handed downstream
    typedef struct packed {
        logic print;
        logic save;
    } trig_type;

    // ----------------------------------------------------------------
    // Limits and timing
    // ----------------------------------------------------------------
    localparam logic [6:0] HOURS_MAX = 7'h63;
    localparam logic [5:0] MINSEC_MAX = 6'h3B;
    localparam int CLK_HZ = 40000000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_S;
    localparam int PERIOD15_MIN = 15;
    localparam int PERIOD2H_HOURS = 2;
    localparam logic [12:0] PERIOD15_S = 13'(PERIOD15_MIN * 60);
    localparam logic [12:0] PERIOD2H_S = 13'(PERIOD2H_HOURS * 3600);
    localparam int SLOT_COUNT = 12;
    localparam logic [3:0] SLOT_FIRST = 4'h1;
    localparam logic [3:0] SLOT_RESET = 4'hC;

endpackage

// *** core/period_timer.sv ***
// Periodic interval counter for print and save triggers
`timescale 1ns/10ps
`default_nettype none
module period_timer (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic restart, // New test begins
    input wire logic running, // Test is running
    input wire logic tick, // One-second tick
    input wire logic [12:0] period_s, // Interval in seconds
    output logic fire // One-cycle pulse at interval end
);
    logic [12:0] count_q;

    // ----------------------------------------------------------------
    // Interval counting
    // ----------------------------------------------------------------
    // Counter restarts at every test start so intervals align to it
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= 13'h0000;
            fire <= 1'b0;
        end else if (ce) begin
            fire <= 1'b0;
            if (restart || !running) begin
                count_q <= 13'h0000;
            end else if (tick) begin
                if (count_q + 13'h0001 >= period_s) begin
                    count_q <= 13'h0000;
                    fire <= 1'b1;
                end else begin
                    count_q <= count_q + 13'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** core/test_run_sequencer.sv ***
// Test-run sequencer: duration modes, triggers, slot pointer, IRQ
//
// Overview of operation
// - Continuous mode: start begins a test, runs until stop.
// - Single timed: run programmed duration once, stop early on request.
// - Repeat timed: rerun after each duration until stop.
// - Duration held as hours, minutes, seconds up to 99:59:59.
// - Timed mode with zero duration runs continuously.
// - Print selector: off, timed end, or error during test.
// - Periodic print every 15 minutes or 2 hours while running.
// - Each automatic save goes to the next higher slot.
// - After slot twelve, saving wraps to slot one.
// - Save selector: off, timed end, or error during test.
// - Periodic save every 15 minutes or 2 hours while running.
// - Auto launch starts a test on entering the operation view.
`timescale 1ns/10ps
`default_nettype none
module test_run_sequencer #(
    parameter int TICK_DIV = test_run_pkg::TICK_CYCLES // Cycles per second
) (
    input wire logic CORE_CLK, // System clock, 40 MHz
    input wire logic RST, // Synchronous reset, active high
    input wire logic CE, // Clock enable
    input wire logic START_REQ, // Front-panel start pulse
    input wire logic STOP_REQ, // Front-panel stop pulse
    input wire logic VIEW_OPERATE, // Level: operation view shown
    input wire logic ERROR_SEEN, // Pulse: error detected
    input wire logic [7:0] ADDR, // Register address
    input wire logic [31:0] WDATA, // Register write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [31:0] RDATA, // Read data, cycle after read
    output test_run_pkg::trig_type TRIG, // Print and save pulses
    output logic [3:0] SLOT, // Slot of the last save
    output logic RUNNING, // Test running
    output logic IRQ // Level interrupt
);
    import test_run_pkg::*;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DUR = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_EN = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFF_ELAPSED = 8'h18;
    localparam logic [3:0] IRQ_NONE = 4'h0;
    localparam hms_type DUR_RESET = hms_type'(19'h00040); // 00:01:00

    // Duration is kept in range: fields above the limit saturate
    function automatic hms_type clamp_hms(input logic [31:0] w);
        hms_type h;
        h.hours = (w[22:16] > HOURS_MAX) ? HOURS_MAX : w[22:16];
        h.minutes = (w[13:8] > MINSEC_MAX) ? MINSEC_MAX : w[13:8];
        h.seconds = (w[5:0] > MINSEC_MAX) ? MINSEC_MAX : w[5:0];
        return h;
    endfunction

    // Event selected by a trigger mode
    function automatic logic trig_hit(input trig_mode_type m,
            input logic ended, input logic err, input logic p15,
            input logic p2h);
        case (m)
            TRIG_END: trig_hit = ended;
            TRIG_ERROR: trig_hit = err;
            TRIG_EVERY15: trig_hit = p15;
            TRIG_EVERY2H: trig_hit = p2h;
            default: trig_hit = 1'b0;
        endcase
    endfunction

    dur_mode_type dur_mode_q;
    trig_mode_type print_mode_q, save_mode_q;
    logic auto_launch_q;
    hms_type dur_q, elapsed_q;
    run_state_type state_q;
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic view_q;
    logic [3:0] slot_q;
    logic [3:0] irq_stat_q, irq_en_q;
    logic timed_end, test_begin, timed, launch;
    logic p15_print, p2h_print, p15_save, p2h_save;
    logic do_print, do_save, err_run;

    assign timed = (dur_mode_q != DUR_CONTINUOUS) &&
                   (dur_q != hms_type'(19'h0));
    assign launch = (START_REQ ||
                     (auto_launch_q && VIEW_OPERATE && !view_q));
    assign test_begin = CE && (state_q != ST_RUN) && launch && !STOP_REQ;
    assign timed_end = timed && (state_q == ST_RUN) && tick_q &&
                       (elapsed_q.seconds + 6'h01 == dur_q.seconds ||
                        dur_q.seconds == 6'h00) &&
                       (next_hms(elapsed_q) == dur_q);
    assign err_run = ERROR_SEEN && (state_q == ST_RUN);

    // Next elapsed time on one tick, hh:mm:ss carry chain, hours hold at 99
    function automatic hms_type next_hms(input hms_type t);
        hms_type n;
        n = t;
        if (t.seconds == MINSEC_MAX) begin
            n.seconds = 6'h00;
            if (t.minutes == MINSEC_MAX) begin
                n.minutes = 6'h00;
                n.hours = (t.hours == HOURS_MAX) ? t.hours : t.hours + 7'h01;
            end else begin
                n.minutes = t.minutes + 6'h01;
            end
        end else begin
            n.seconds = t.seconds + 6'h01;
        end
        return n;
    endfunction

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            dur_mode_q <= DUR_CONTINUOUS;
            print_mode_q <= TRIG_OFF;
            save_mode_q <= TRIG_OFF;
            auto_launch_q <= 1'b0;
            dur_q <= DUR_RESET;
        end else if (CE && WR) begin
            if (ADDR == OFF_CTRL) begin
                dur_mode_q <= (WDATA[1:0] == 2'h3) ? DUR_CONTINUOUS
                                                   : dur_mode_type'(WDATA[1:0]);
                print_mode_q <= (WDATA[6:4] > 3'h4) ? TRIG_OFF
                                                    : trig_mode_type'(WDATA[6:4]);
                save_mode_q <= (WDATA[10:8] > 3'h4) ? TRIG_OFF
                                                    : trig_mode_type'(WDATA[10:8]);
                auto_launch_q <= WDATA[12];
            end
            if (ADDR == OFF_DUR) begin
                dur_q <= clamp_hms(WDATA);
            end
        end
    end

    // ----------------------------------------------------------------
    // One-second tick
    // ----------------------------------------------------------------
    // Tick is free running; a test may see its first second short
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else if (CE) begin
            tick_q <= 1'b0;
            if (tick_cnt_q >= 32'(TICK_DIV - 1)) begin
                tick_cnt_q <= 32'h0000_0000;
                tick_q <= 1'b1;
            end else begin
                tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Run state machine
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
            view_q <= 1'b0;
        end else if (CE) begin
            view_q <= VIEW_OPERATE;
            case (state_q)
                ST_IDLE: begin
                    if (launch && !STOP_REQ) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (STOP_REQ) begin
                        state_q <= ST_IDLE;
                    end else if (timed_end) begin
                        if (dur_mode_q == DUR_REPEAT) begin
                            state_q <= ST_END;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_END: begin
                    // One-cycle gap before the repeat restarts
                    state_q <= STOP_REQ ? ST_IDLE : ST_RUN;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Elapsed time
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            elapsed_q <= hms_type'(19'h0);
        end else if (CE) begin
            if (test_begin || state_q == ST_END) begin
                elapsed_q <= hms_type'(19'h0);
            end else if (state_q == ST_RUN && tick_q) begin
                elapsed_q <= next_hms(elapsed_q);
            end
        end
    end

    // ----------------------------------------------------------------
    // Periodic interval counters
    // ----------------------------------------------------------------
    period_timer u_p15_print (
        .clk(CORE_CLK), .rst(RST), .ce(CE), .restart(test_begin),
        .running(state_q == ST_RUN), .tick(tick_q),
        .period_s(PERIOD15_S), .fire(p15_print)
    );
    period_timer u_p2h_print (
        .clk(CORE_CLK), .rst(RST), .ce(CE), .restart(test_begin),
        .running(state_q == ST_RUN), .tick(tick_q),
        .period_s(PERIOD2H_S), .fire(p2h_print)
    );
    period_timer u_p15_save (
        .clk(CORE_CLK), .rst(RST), .ce(CE), .restart(test_begin),
        .running(state_q == ST_RUN), .tick(tick_q),
        .period_s(PERIOD15_S), .fire(p15_save)
    );
    period_timer u_p2h_save (
        .clk(CORE_CLK), .rst(RST), .ce(CE), .restart(test_begin),
        .running(state_q == ST_RUN), .tick(tick_q),
        .period_s(PERIOD2H_S), .fire(p2h_save)
    );

    assign do_print = trig_hit(print_mode_q, timed_end, err_run,
                               p15_print, p2h_print);
    assign do_save = trig_hit(save_mode_q, timed_end, err_run,
                              p15_save, p2h_save);

    // ----------------------------------------------------------------
    // Trigger pulses and slot pointer
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            TRIG <= '0;
            slot_q <= SLOT_RESET;
        end else if (CE) begin
            TRIG.print <= do_print;
            TRIG.save <= do_save;
            if (do_save) begin
                slot_q <= (slot_q >= 4'(SLOT_COUNT)) ? SLOT_FIRST
                                                     : slot_q + 4'h1;
            end
        end
    end
    assign SLOT = slot_q;

    // ----------------------------------------------------------------
    // Interrupt status: start, end, print, save
    // ----------------------------------------------------------------
    // Set wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            irq_stat_q <= IRQ_NONE;
            irq_en_q <= IRQ_NONE;
            IRQ <= 1'b0;
        end else if (CE) begin
            irq_stat_q <= (irq_stat_q &
                           ~((WR && ADDR == OFF_IRQ_CLR) ? WDATA[3:0] : 4'h0))
                          | {do_save, do_print, timed_end, test_begin};
            if (WR && ADDR == OFF_IRQ_EN) begin
                irq_en_q <= WDATA[3:0];
            end
            IRQ <= |(irq_stat_q & irq_en_q);
        end
    end

    // ----------------------------------------------------------------
    // Outputs and read port
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            RDATA <= 32'h0000_0000;
            RUNNING <= 1'b0;
        end else if (CE) begin
            RUNNING <= (state_q != ST_IDLE);
            RDATA <= 32'h0000_0000;
            if (RD) begin
                case (ADDR)
                    OFF_CTRL: RDATA <= {19'h0, auto_launch_q, 1'b0,
                        save_mode_q, 1'b0, print_mode_q, 2'h0, dur_mode_q};
                    OFF_DUR: RDATA <= {9'h0, dur_q.hours, 2'h0,
                        dur_q.minutes, 2'h0, dur_q.seconds};
                    OFF_STAT: RDATA <= {24'h0, slot_q, 2'h0, state_q};
                    OFF_IRQ_STAT: RDATA <= {28'h0, irq_stat_q};
                    OFF_IRQ_EN: RDATA <= {28'h0, irq_en_q};
                    OFF_ELAPSED: RDATA <= {9'h0, elapsed_q.hours, 2'h0,
                        elapsed_q.minutes, 2'h0, elapsed_q.seconds};
                    default: RDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_stop_ends_run: assert property (@(posedge CORE_CLK) disable iff (RST)
        (CE && state_q == ST_RUN && STOP_REQ) |=> state_q == ST_IDLE)
        else $error("stop did not end the run");
    a_single_stops: assert property (@(posedge CORE_CLK) disable iff (RST)
        (CE && timed_end && !STOP_REQ && dur_mode_q == DUR_SINGLE)
        |=> state_q == ST_IDLE)
        else $error("single timed test did not stop");
    a_repeat_restarts: assert property (@(posedge CORE_CLK) disable iff (RST)
        (CE && timed_end && !STOP_REQ && dur_mode_q == DUR_REPEAT)
        |=> state_q == ST_END)
        else $error("repeat test did not restart");
    a_dur_in_range: assert property (@(posedge CORE_CLK) disable iff (RST)
        dur_q.hours <= HOURS_MAX && dur_q.minutes <= MINSEC_MAX &&
        dur_q.seconds <= MINSEC_MAX)
        else $error("duration out of range");
    a_zero_no_end: assert property (@(posedge CORE_CLK) disable iff (RST)
        (dur_q == hms_type'(19'h0)) |-> !timed_end)
        else $error("zero duration ended a test");
    a_print_off: assert property (@(posedge CORE_CLK) disable iff (RST)
        (CE && print_mode_q == TRIG_OFF) |=> !TRIG.print)
        else $error("print raised while off");
    a_save_off: assert property (@(posedge CORE_CLK) disable iff (RST)
        (CE && save_mode_q == TRIG_OFF) |=> !TRIG.save)
        else $error("save raised while off");
    a_slot_step: assert property (@(posedge CORE_CLK) disable iff (RST)
        (CE && do_save) |=> SLOT == (($past(SLOT) == 4'hC) ? 4'h1
                                   : $past(SLOT) + 4'h1))
        else $error("slot pointer did not step");
    a_slot_range: assert property (@(posedge CORE_CLK) disable iff (RST)
        SLOT >= 4'h1 && SLOT <= 4'hC)
        else $error("slot out of range");
    a_trig_pulse: assert property (@(posedge CORE_CLK) disable iff (RST)
        (CE && TRIG.print && !do_print) |=> !TRIG.print)
        else $error("print trigger stuck");
    a_auto_launch: assert property (@(posedge CORE_CLK) disable iff (RST)
        (CE && state_q == ST_IDLE && auto_launch_q && VIEW_OPERATE &&
         !view_q && !STOP_REQ) |=> state_q == ST_RUN)
        else $error("auto launch missed");
endmodule
`default_nettype wire

// *** testbench/result_sink_model.sv ***
// Far-side model: printer and result memory taking trigger pulses
`timescale 1ns/10ps
`default_nettype none
module result_sink_model (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire test_run_pkg::trig_type trig, // Print and save pulses
    input wire logic [3:0] slot, // Slot of the last save
    output int prints, // Print jobs taken
    output int saves, // Results stored
    output logic [3:0] last_slot // Slot written last
);
    import test_run_pkg::*;
    // ------------------------------------------------------------
    // Job intake
    // ------------------------------------------------------------
    // One job per pulse; a stretched pulse would show as extra jobs
    always_ff @(posedge clk) begin
        if (rst) begin
            prints <= 0;
            saves <= 0;
            last_slot <= 4'h0;
        end else begin
            if (trig.print) prints <= prints + 1;
            if (trig.save) begin
                saves <= saves + 1;
                last_slot <= slot; // Slot already advanced with the pulse
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/test_run_sequencer_tb_top.sv ***
// Self-checking bench for the test-run sequencer
`timescale 1ns/10ps
`default_nettype none
module test_run_sequencer_tb_top;
    import test_run_pkg::*;
    localparam int DIV = 4; // Short second keeps the 2 h interval simulable
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic start_req = 1'b0;
    logic stop_req = 1'b0;
    logic view_op = 1'b0;
    logic err_seen = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata, v, x;
    trig_type trig;
    logic [3:0] slot, last_slot, exp_slot;
    logic running, irq;
    int prints, saves, err_total, checks_done, seed, p0, s0;
    // Free-running system clock, 25 ns period
    always #12.5 clk = ~clk;
    test_run_sequencer #(.TICK_DIV(DIV)) DUT (.CORE_CLK(clk), .RST(rst),
        .CE(ce), .START_REQ(start_req), .STOP_REQ(stop_req),
        .VIEW_OPERATE(view_op), .ERROR_SEEN(err_seen), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TRIG(trig),
        .SLOT(slot), .RUNNING(running), .IRQ(irq));
    result_sink_model sink (.clk(clk), .rst(rst), .trig(trig), .slot(slot),
        .prints(prints), .saves(saves), .last_slot(last_slot));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic keys(input logic st, input logic sp);
        @(posedge clk);
        start_req <= st;
        stop_req <= sp;
        @(posedge clk);
        start_req <= 1'b0;
        stop_req <= 1'b0;
    endtask
    task automatic wait_save(input int n);
        int s;
        s = saves;
        repeat (n) begin
            cyc(1);
            if (saves != s) break;
        end
    endtask
    function automatic logic [3:0] nxt(input logic [3:0] s);
        return (s == 4'hC) ? 4'h1 : s + 4'h1;
    endfunction
    // Out-of-range fields clamp to their largest legal value
    function automatic logic [31:0] dur_exp(input logic [31:0] w);
        logic [6:0] h;
        logic [5:0] m, s;
        h = (w[22:16] > HOURS_MAX) ? HOURS_MAX : w[22:16];
        m = (w[13:8] > MINSEC_MAX) ? MINSEC_MAX : w[13:8];
        s = (w[5:0] > MINSEC_MAX) ? MINSEC_MAX : w[5:0];
        return {9'h0, h, 2'h0, m, 2'h0, s};
    endfunction
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Watchdog sized well past the longest periodic run
    initial begin
        #(25 * 60000);
        err_total++;
        end_of_test;
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        seed = 47;
        err_total = 0;
        checks_done = 0;
        exp_slot = 4'hC;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        chk("slot", {28'h0, slot}, {28'h0, exp_slot});
        rreg(8'h04, v);
        chk("dur default", v, 32'h100);
        rreg(8'h1C, v);
        chk("unmapped", v, 32'h0);
        for (int i = 0; i < 8; i++) begin
            x = (i == 0) ? 32'h00633B3B : $random(seed);
            wreg(8'h04, x);
            rreg(8'h04, v);
            chk("dur", v, dur_exp(x));
        end
        // Illegal duration mode and trigger codes fall back to safe values
        wreg(8'h00, 32'h1773);
        rreg(8'h00, v);
        chk("ctrl clamp", v, 32'h1000);
        $display("done: reset and duration");
        wreg(8'h10, 32'h1);
        keys(1'b1, 1'b0);
        cyc(3);
        chk("irq", {31'h0, irq}, 32'h1);
        cyc(60);
        chk("running", {31'h0, running}, 32'h1);
        // A stop while the clock enable is low must be ignored
        @(posedge clk);
        ce <= 1'b0;
        keys(1'b0, 1'b1);
        cyc(3);
        chk("frozen", {31'h0, running}, 32'h1);
        @(posedge clk);
        ce <= 1'b1;
        keys(1'b0, 1'b1);
        wreg(8'h14, 32'hF);
        wreg(8'h10, 32'h0);
        cyc(3);
        chk("stopped", {31'h0, running}, 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wreg(8'h04, 32'h0);
        wreg(8'h00, 32'h1);
        keys(1'b1, 1'b0);
        cyc(60);
        chk("zero dur", {31'h0, running}, 32'h1);
        keys(1'b0, 1'b1);
        $display("done: continuous");
        wreg(8'h04, 32'h3);
        wreg(8'h00, 32'h111);
        p0 = prints;
        s0 = saves;
        keys(1'b1, 1'b0);
        wait_save(40);
        exp_slot = nxt(exp_slot);
        chk("end saves", 32'(saves - s0), 32'h1);
        chk("end prints", 32'(prints - p0), 32'h1);
        chk("slot", {28'h0, last_slot}, {28'h0, exp_slot});
        cyc(3);
        chk("single end", {31'h0, running}, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rreg(8'h0C, v);
        chk("irq stat", v, 32'hF);
        keys(1'b1, 1'b0);
        cyc(4);
        keys(1'b0, 1'b1);
        cyc(20);
        chk("early stop", 32'(saves - s0), 32'h1);
        $display("done: single timed");
        wreg(8'h04, 32'h2);
        wreg(8'h00, 32'h102);
        p0 = prints;
        keys(1'b1, 1'b0);
        for (int i = 0; i < 13; i++) begin
            wait_save(30);
            exp_slot = nxt(exp_slot);
            chk("wrap slot", {28'h0, last_slot}, {28'h0, exp_slot});
            chk("repeat", {31'h0, running}, 32'h1);
        end
        keys(1'b0, 1'b1);
        chk("print off", 32'(prints - p0), 32'h0);
        $display("done: repeat and wrap");
        wreg(8'h00, 32'h220);
        keys(1'b1, 1'b0);
        for (int i = 0; i < 2; i++) begin
            cyc(3 + ($random(seed) & 7));
            p0 = prints;
            s0 = saves;
            @(posedge clk);
            err_seen <= 1'b1;
            @(posedge clk);
            err_seen <= 1'b0;
            cyc(4);
            if (i == 0) exp_slot = nxt(exp_slot);
            chk("err print", 32'(prints - p0), 32'(1 - i));
            chk("err save", 32'(saves - s0), 32'(1 - i));
            if (i == 0) keys(1'b0, 1'b1);
        end
        chk("slot", {28'h0, slot}, {28'h0, exp_slot});
        rreg(8'h08, v);
        chk("stat", v, {24'h0, exp_slot, 4'h0});
        $display("done: error triggers");
        wreg(8'h00, 32'h1000);
        view_op <= 1'b1;
        cyc(4);
        chk("auto on", {31'h0, running}, 32'h1);
        keys(1'b0, 1'b1);
        view_op <= 1'b0;
        wreg(8'h00, 32'h0);
        view_op <= 1'b1;
        cyc(4);
        chk("auto off", {31'h0, running}, 32'h0);
        @(posedge clk);
        view_op <= 1'b0;
        $display("done: auto launch");
        wreg(8'h00, 32'h430);
        keys(1'b1, 1'b0);
        cyc(3000);
        keys(1'b0, 1'b1);
        p0 = prints;
        s0 = saves;
        keys(1'b1, 1'b0);
        cyc(3500);
        chk("restart", 32'(prints - p0), 32'h0);
        cyc(25320);
        chk("every 15", 32'(prints - p0), 32'h8);
        chk("every 2h", 32'(saves - s0), 32'h1);
        exp_slot = nxt(exp_slot);
        chk("slot", {28'h0, last_slot}, {28'h0, exp_slot});
        keys(1'b0, 1'b1);
        // Swapped intervals: save every 15 min, print every 2 h
        wreg(8'h00, 32'h340);
        p0 = prints;
        s0 = saves;
        keys(1'b1, 1'b0);
        cyc(3620);
        chk("save 15", 32'(saves - s0), 32'h1);
        chk("print 2h", 32'(prints - p0), 32'h0);
        keys(1'b0, 1'b1);
        $display("done: periodic");
        end_of_test;
    end
endmodule
`default_nettype wire
